/* File: rtcci_top.sv */
// real-time clock core: counters, command, mask and status over Avalon-MM
// assumes a single 25 MHz clock and a master that holds its request while waitrequest is high
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
module rtcci_top import rtcci_pkg::*; #(
  parameter int unsigned HUND_CYCLES = RTCCI_HUND_CYCLES
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // interrupt request to the slave controller
  output logic             slave_request_input_six_out
);

  rtcci_state_type st_r;
  rtcci_state_type st_nxt;
  rtcci_tick_if    tick_if ();

  logic       req;
  logic       accept;
  logic       sec_evt;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  ////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets read as zero
  function automatic logic [31:0] rd_mux(input logic [4:0] a, input rtcci_state_type s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == RTCCI_OFS_HUND) begin
      d = {25'h0000000, s.hund};
    end else if (a == RTCCI_OFS_SEC) begin
      d = {24'h000000, s.sec};
    end else if (a == RTCCI_OFS_CMD) begin
      d = {24'h000000, s.cmd};
    end else if (a == RTCCI_OFS_MASK) begin
      d = {24'h000000, s.mask};
    end else if (a == RTCCI_OFS_STAT) begin
      d = {24'h000000, s.pend};
    end
    return d;
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////
  // hundredth-second divider
  rtcci_tick #(
    .CYCLES   (HUND_CYCLES)
  ) rtcci_tick_i (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tick_if  (tick_if)
  );

  ////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the request is taken
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~st_r.ack;
  assign accept              = req & st_r.ack;
  assign avs_readdata_out    = st_r.rdata;

  // interrupt events and clears
  assign sec_evt = tick_if.hund_tick && (st_r.hund == RTCCI_HUND_LAST);
  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[RTCCI_SRC_HUND_BIT] = tick_if.hund_tick & st_r.cmd[RTCCI_CMD_INT_EN_BIT]
                                & st_r.mask[RTCCI_SRC_HUND_BIT];
    set_v[RTCCI_SRC_SEC_BIT]  = sec_evt & st_r.cmd[RTCCI_CMD_INT_EN_BIT]
                                & st_r.mask[RTCCI_SRC_SEC_BIT];
    if (accept && avs_read_in && avs_address_in == RTCCI_OFS_STAT) begin
      clr_v = st_r.cap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    // counters run regardless of bus traffic or command
    if (tick_if.hund_tick) begin
      if (st_r.hund == RTCCI_HUND_LAST) begin
        st_nxt.hund = '0;
        st_nxt.sec  = (st_r.sec == RTCCI_SEC_LAST) ? 8'h00 : st_r.sec + 8'h01;
      end else begin
        st_nxt.hund = st_r.hund + 7'h01;
      end
    end
    // first cycle of a request captures data, second takes it
    if (req && !st_r.ack) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = rd_mux(avs_address_in, st_r);
      st_nxt.cap   = st_r.pend;
    end else begin
      st_nxt.ack = 1'b0;
    end
    // register writes on the low byte lane
    if (accept && avs_write_in && avs_byteenable_in[0]) begin
      if (avs_address_in == RTCCI_OFS_CMD) begin
        st_nxt.cmd = avs_writedata_in[7:0];
      end else if (avs_address_in == RTCCI_OFS_MASK) begin
        st_nxt.mask = avs_writedata_in[7:0];
      end
    end
    // set wins over clear
    st_nxt.pend = (st_r.pend & ~clr_v) | set_v;
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r      <= '0;
      st_r.cmd  <= RTCCI_CMD_RESET;
      st_r.mask <= RTCCI_MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // request only for pending sources still unmasked
  assign slave_request_input_six_out = |(st_r.pend & st_r.mask);

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_req_wait;
    req && avs_waitrequest_out;
  endsequence
  sequence s_req_taken;
    !avs_waitrequest_out;
  endsequence
  sequence s_stat_read;
    accept && avs_read_in && avs_address_in == RTCCI_OFS_STAT;
  endsequence

  property p_one_wait;
    s_req_wait |=> s_req_taken;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest held too long");

  property p_hund_step;
    (tick_if.hund_tick && st_r.hund != RTCCI_HUND_LAST) |=> (st_r.hund == $past(st_r.hund) + 7'h01);
  endproperty
  a_hund_step: assert property (p_hund_step) else $error("hundredths did not advance");

  property p_hund_wrap;
    sec_evt |=> (st_r.hund == 7'h00 && st_r.sec != $past(st_r.sec));
  endproperty
  a_hund_wrap: assert property (p_hund_wrap) else $error("seconds did not advance");

  property p_read_no_disturb;
    (avs_read_in && !tick_if.hund_tick) |=> $stable(st_r.hund) && $stable(st_r.sec);
  endproperty
  a_read_no_disturb: assert property (p_read_no_disturb) else $error("read disturbed counters");

  property p_mask_zero;
    (st_r.mask == 8'h00) |-> !slave_request_input_six_out;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("request with mask zero");

  // a taken write of zero to the mask drops the request on the next cycle
  property p_mask_write_zero;
    (accept && avs_write_in && avs_byteenable_in[0] && avs_address_in == RTCCI_OFS_MASK
      && avs_writedata_in[7:0] == 8'h00) |=> !slave_request_input_six_out;
  endproperty
  a_mask_write_zero: assert property (p_mask_write_zero) else $error("request after mask zero write");

  property p_stat_clear;
    (s_stat_read and (set_v == 8'h00) and (st_r.pend == st_r.cap)) |=> !slave_request_input_six_out;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read left request");

  property p_idle_low;
    (st_r.pend == 8'h00) |-> !slave_request_input_six_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("request without pending");

  property p_hund_raise;
    (st_r.cmd == RTCCI_CMD_HUND_ON && st_r.mask == RTCCI_MASK_HUND_ON && tick_if.hund_tick)
      |=> (st_r.pend[RTCCI_SRC_HUND_BIT] && slave_request_input_six_out);
  endproperty
  a_hund_raise: assert property (p_hund_raise) else $error("hundredth interrupt missing");

  property p_hund_stop;
    (st_r.cmd == RTCCI_CMD_HUND_OFF && !st_r.pend[RTCCI_SRC_HUND_BIT]) |=> !st_r.pend[RTCCI_SRC_HUND_BIT];
  endproperty
  a_hund_stop: assert property (p_hund_stop) else $error("interrupt after stop");

  property p_sec_raise;
    (sec_evt && st_r.cmd[RTCCI_CMD_INT_EN_BIT] && st_r.mask[RTCCI_SRC_SEC_BIT])
      |=> st_r.pend[RTCCI_SRC_SEC_BIT];
  endproperty
  a_sec_raise: assert property (p_sec_raise) else $error("second interrupt missing");
endmodule : rtcci_top

/* File: rtcci_pkg.sv */
// constants and types shared by the real-time clock block
// assumes a 25 MHz system clock and an Avalon-MM slave register port
// What this block does
// - counters advance continuously, reads see change
// - reading counters never disturbs the clock
// - mask value zero blocks every interrupt
// - status read clears pending, drops request
// - request line low while nothing pending
// - command 18, mask 02 raise hundredth interrupt
// - hundredth interrupt arrives within 10 ms
// - command 08 stops interrupt, clock keeps running
// - one-second interrupt fires every second
package rtcci_pkg;
  // timing
  localparam int unsigned RTCCI_CLK_PERIOD_NS  = 40;
  localparam int unsigned RTCCI_HUND_PERIOD_MS = 10;
  localparam int unsigned RTCCI_HUND_CYCLES    = (RTCCI_HUND_PERIOD_MS * 1000000) / RTCCI_CLK_PERIOD_NS;
  localparam logic [6:0]  RTCCI_HUND_LAST      = 7'h63;
  localparam logic [7:0]  RTCCI_SEC_LAST       = 8'h3b;
  // register byte offsets
  localparam logic [4:0]  RTCCI_OFS_HUND       = 5'h00;
  localparam logic [4:0]  RTCCI_OFS_SEC        = 5'h04;
  localparam logic [4:0]  RTCCI_OFS_CMD        = 5'h08;
  localparam logic [4:0]  RTCCI_OFS_MASK       = 5'h0c;
  localparam logic [4:0]  RTCCI_OFS_STAT       = 5'h10;
  // field positions
  localparam int unsigned RTCCI_CMD_INT_EN_BIT = 4;
  localparam int unsigned RTCCI_SRC_HUND_BIT   = 1;
  localparam int unsigned RTCCI_SRC_SEC_BIT    = 2;
  // reset values, then command and mask settings for the hundredth source
  localparam logic [7:0]  RTCCI_CMD_RESET      = 8'h08;
  localparam logic [7:0]  RTCCI_MASK_RESET     = 8'h00;
  localparam logic [7:0]  RTCCI_CMD_HUND_ON    = 8'h18;
  localparam logic [7:0]  RTCCI_CMD_HUND_OFF   = 8'h08;
  localparam logic [7:0]  RTCCI_MASK_HUND_ON   = 8'h02;

  typedef struct packed {
    logic [6:0]  hund;
    logic [7:0]  sec;
    logic [7:0]  cmd;
    logic [7:0]  mask;
    logic [7:0]  pend;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  cap;
  } rtcci_state_type;
endpackage : rtcci_pkg

/* File: rtcci_tick_if.sv */
// carries the hundredth-second tick from the divider to the clock core
// assumes both ends share clock_in
`timescale 1ns/1ns
interface rtcci_tick_if;
  logic hund_tick;
  modport src (output hund_tick);
  modport snk (input hund_tick);
endinterface : rtcci_tick_if

/* File: rtcci_tick.sv */
// divider that makes one pulse every hundredth of a second
// assumes a free-running clock_in and a synchronous reset
`timescale 1ns/1ns
module rtcci_tick import rtcci_pkg::*; #(
  parameter int unsigned CYCLES = RTCCI_HUND_CYCLES
) (
  // clock and reset
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  // tick toward the core
  rtcci_tick_if.src   tick_if
);
  localparam int unsigned W = $clog2(CYCLES);
  localparam logic [W-1:0] TOP = W'(CYCLES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } rtcci_tick_state_type;

  rtcci_tick_state_type st_r;
  rtcci_tick_state_type st_nxt;

  ////////////////////////////////////////////////////////////////
  // count cycles and pulse at the end of each period
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == TOP) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_if.hund_tick = st_r.tick;

  ////////////////////////////////////////////////////////////////
  // checks
  property p_tick_at_top;
    @(posedge clock_in) disable iff (rst_in)
      (st_r.cnt == TOP) |=> (st_r.tick && st_r.cnt == '0);
  endproperty
  a_tick_at_top: assert property (p_tick_at_top) else $error("tick missing at period end");

  property p_tick_only_at_wrap;
    @(posedge clock_in) disable iff (rst_in)
      st_r.tick |-> (st_r.cnt == '0);
  endproperty
  a_tick_only_at_wrap: assert property (p_tick_only_at_wrap) else $error("tick away from wrap");
endmodule : rtcci_tick

/* File: rtcci_host_model.sv */
// host-side model of the two cascaded interrupt controllers
// assumes active-high mask bits set by the bench
`timescale 1ns/1ns
module rtcci_host_model (
  // request from the clock block
  input  wire logic       slave_request_input_six_in,
  // controller mask registers
  input  wire logic [7:0] slave_mask_in,
  input  wire logic [7:0] master_mask_in,
  // interrupt seen by the processor
  output logic            cpu_int_out
);
  // slave bit six and master cascade bit three both gate the path
  assign cpu_int_out = slave_request_input_six_in & ~slave_mask_in[6] & ~master_mask_in[3];
endmodule : rtcci_host_model

/* File: rtcci_bench.sv */
// self-checking bench for the real-time clock block
// assumes a short tick period and the host model beside it
`timescale 1ns/1ns
module rtcci_bench import rtcci_pkg::*;;
  localparam int unsigned HC = 20;
  typedef struct packed {logic wr; logic [4:0] a; logic [7:0] d; logic [31:0] e;} rtcci_row_type;
  logic        clock_in, rst_in, avs_read_in, avs_write_in, irq, cpu_int, prev;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q, h0, h1;
  logic        avs_waitrequest_out;
  logic [7:0]  smask, mmask;
  logic [3:0]  be;
  int          n_errors, n_checks, cyc;
  time         t_rise [2];
  rtcci_row_type rows [8] = '{
    '{1'b0, RTCCI_OFS_CMD, 8'h00, 32'h08}, '{1'b0, RTCCI_OFS_MASK, 8'h00, 32'h00},
    '{1'b0, 5'h14, 8'h00, 32'h00}, '{1'b1, RTCCI_OFS_CMD, 8'h18, 32'h00},
    '{1'b0, RTCCI_OFS_CMD, 8'h00, 32'h18}, '{1'b1, 5'h14, 8'ha5, 32'h00},
    '{1'b0, 5'h14, 8'h00, 32'h00}, '{1'b0, RTCCI_OFS_STAT, 8'h00, 32'h00}};
  ////////////////////////////////////////////////////////////////////////////////
  // design and host model
  rtcci_top #(.HUND_CYCLES(HC)) rtcci_top_i (.clock_in(clock_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .slave_request_input_six_out(irq));
  rtcci_host_model rtcci_host_model_i (.slave_request_input_six_in(irq), .slave_mask_in(smask),
    .master_mask_in(mmask), .cpu_int_out(cpu_int));
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // timeout and request rise times
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    prev <= irq;
    if (irq === 1'b1 && prev !== 1'b1) begin
      t_rise[0] <= t_rise[1];
      t_rise[1] <= $time;
    end
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] r);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus
  task automatic wait_irq(input int max);
    for (int k = 0; k < max && irq !== 1'b1; k++) @(posedge clock_in);
  endtask : wait_irq
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_in, avs_read_in, avs_write_in, prev} = 4'h8;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h00000000;
    be = 4'hf;
    {smask, mmask} = 16'hffff;
    {n_errors, n_checks, cyc} = '0;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    // table of register accesses
    for (int i = 0; i < 8; i++) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) check(q, rows[i].e);
    end
    // mask zero keeps the request low while generation is on
    repeat (3 * HC) @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    // counters move across reads
    bus(1'b0, RTCCI_OFS_HUND, 8'h00, h0);
    repeat (3 * HC) @(posedge clock_in);
    bus(1'b0, RTCCI_OFS_HUND, 8'h00, h1);
    check({31'h0, h1 !== h0}, 32'h1);
    repeat (100 * HC) @(posedge clock_in);
    bus(1'b0, RTCCI_OFS_SEC, 8'h00, q);
    check({31'h0, q != 0 && q < 60}, 32'h1);
    // open the controllers, then the hundredth source
    smask <= 8'hbf;
    mmask <= 8'hf7;
    bus(1'b1, RTCCI_OFS_MASK, RTCCI_MASK_HUND_ON, q);
    wait_irq(HC + 4);
    check({31'h0, irq}, 32'h1);
    check({31'h0, cpu_int}, 32'h1);
    bus(1'b0, RTCCI_OFS_STAT, 8'h00, q);
    check(q & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    // closing the controllers blocks the request
    wait_irq(HC + 4);
    smask <= 8'hff;
    mmask <= 8'hff;
    @(posedge clock_in);
    check({31'h0, cpu_int}, 32'h0);
    // stop command ends the source but not the clock
    bus(1'b1, RTCCI_OFS_CMD, RTCCI_CMD_HUND_OFF, q);
    bus(1'b0, RTCCI_OFS_STAT, 8'h00, q);
    bus(1'b0, RTCCI_OFS_HUND, 8'h00, h0);
    repeat (3 * HC) @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, RTCCI_OFS_HUND, 8'h00, h1);
    check({31'h0, h1 !== h0}, 32'h1);
    // one-second source and its period
    bus(1'b1, RTCCI_OFS_MASK, 8'h04, q);
    bus(1'b1, RTCCI_OFS_CMD, RTCCI_CMD_HUND_ON, q);
    wait_irq(100 * HC + 4);
    bus(1'b0, RTCCI_OFS_STAT, 8'h00, q);
    check(q & 32'h4, 32'h4);
    wait_irq(100 * HC + 4);
    @(posedge clock_in);
    check(32'(t_rise[1] - t_rise[0]), 32'(100 * HC * 40));
    // writing mask zero drops the pending request at once, status still shows it
    bus(1'b1, RTCCI_OFS_MASK, 8'h00, q);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, RTCCI_OFS_STAT, 8'h00, q);
    check(q & 32'h4, 32'h4);
    // reset in mid-run restores defaults and drops the request
    rst_in <= 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, RTCCI_OFS_CMD, 8'h00, q);
    check(q, {24'h0, RTCCI_CMD_RESET});
    bus(1'b0, RTCCI_OFS_STAT, 8'h00, q);
    check(q, 32'h0);
    // a write without the low byte lane stores nothing
    be <= 4'he;
    bus(1'b1, RTCCI_OFS_CMD, RTCCI_CMD_HUND_ON, q);
    be <= 4'hf;
    bus(1'b0, RTCCI_OFS_CMD, 8'h00, q);
    check(q, {24'h0, RTCCI_CMD_RESET});
    report_and_stop();
  end
endmodule : rtcci_bench
